// ---- hdl/cscm_top.sv ----
// module: configuration status, chain select and crc integrity monitor
// Function
// - hold config_complete low before and during load
// - release config_complete after error-free load, init start
// - after release, initialize then enter user mode
// - external low on config_complete ignored afterwards
// - drive chain_pass_out_n low when configuration completes
// - flash select enables serial or parallel memory
// - check crc per frame; stop on mismatch
// - store whole-stream crc in 32-bit register
// - user mode repeatedly recomputes crc over cells
// - checking runs until restart_config_n goes low
// - only config cells checked, memories excluded
// - ieee 802 crc32, one calculation per pass
// - zero signature clears fault, nonzero sets it
// - storage register writable for error injection
// - fault flag active high only when enabled
// - checker present only on high-core variant
// - tri-state option floats flash pins in user mode
// - boundary-scan load overrides scheme_select_pins
module cscm_top
  import cscm_pkg::*;
#(
  parameter int FRAME_BITS_P = cscm_pkg::FRAME_BITS,  // data bits per frame
  parameter int NUM_FRAMES_P = cscm_pkg::NUM_FRAMES,  // frames per bitstream
  parameter int CELL_W_P     = cscm_pkg::CELL_W,      // cell word width
  parameter int CELL_DEPTH_P = 16,                    // cell words held
  parameter bit HIGH_CORE_P  = 1'b1                   // variant with user-mode checker
) (
  // clock and reset
  input  wire logic                       mclk_i,
  input  wire logic                       srst_i,
  // restart and chain
  input  wire logic                       restart_config_n_i,
  input  wire logic                       chain_select_n_i,
  output logic                            chain_pass_out_n_o,
  output logic                            chain_pass_out_n_oe_n_o,
  // config_complete open-drain pin
  input  wire logic                       config_complete_i,
  output logic                            config_complete_o,
  output logic                            config_complete_oe_n_o,
  // scheme and options
  input  wire cscm_pkg::cscm_scheme_t     scheme_select_pins_i,
  input  wire logic                       boundary_scan_load_i,
  input  wire logic                       tristate_opt_i,
  input  wire logic                       err_detect_en_i,
  // serial stream link
  input  wire logic                       serial_config_clock_i,
  input  wire logic                       serial_data_in_i,
  // flash control pins
  output logic                            serial_flash_select_n_o,
  output logic                            parallel_flash_enable_n_o,
  output logic                            flash_pins_oe_n_o,
  // crc store access
  input  wire logic                       crc_store_wr_i,
  input  wire logic [31:0]                crc_store_data_i,
  output logic [31:0]                     crc_store_o,
  // status
  output logic                            crc_fault_flag_o,
  output logic                            crc_fault_flag_oe_n_o,
  output logic                            frame_crc_error_o,
  output logic                            user_mode_o
);
  import cscm_pkg::*;

  // ----------------------------------------------------------------
  // local sizes
  // ----------------------------------------------------------------
  localparam int FB_W  = $clog2(FRAME_BITS_P + CRC_W + 1);  // bit counter width
  localparam int FR_W  = $clog2(NUM_FRAMES_P + 1);          // frame counter width
  localparam int AD_W  = $clog2(CELL_DEPTH_P);              // cell address width
  localparam int BI_W  = $clog2(CELL_W_P);                  // bit-in-word width
  localparam int IC_W  = $clog2(INIT_CYC + 1);              // init counter width
  localparam logic [FB_W-1:0] FB_DATA = FB_W'(FRAME_BITS_P);
  localparam logic [FB_W-1:0] FB_LAST = FB_W'(FRAME_BITS_P + CRC_W - 1);
  localparam logic [FR_W-1:0] FR_LAST = FR_W'(NUM_FRAMES_P - 1);
  localparam logic [AD_W-1:0] AD_LAST = AD_W'(CELL_DEPTH_P - 1);
  localparam logic [BI_W-1:0] BI_LAST = BI_W'(CELL_W_P - 1);
  localparam logic [IC_W-1:0] IC_LAST = IC_W'(INIT_CYC - 1);

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CSCM_ST_RESET,     // waiting for restart release and chain select
    CSCM_ST_LOAD,      // receiving frames
    CSCM_ST_ERROR,     // frame crc mismatch, parked until restart
    CSCM_ST_INIT,      // initialization cycle
    CSCM_ST_USER,      // user mode
    CSCM_ST_UCHK_END   // final step of the stored-crc check
  } cscm_state_t;

  typedef struct packed {
    cscm_state_t       st;          // main sequence
    logic [SYNC_N-1:0] clk_sy;      // link clock synchroniser
    logic [SYNC_N-1:0] dat_sy;      // link data synchroniser
    logic [SYNC_N-1:0] rst_sy;      // restart synchroniser
    logic [SYNC_N-1:0] ce_sy;       // chain select synchroniser
    logic              clk_q;       // agreed link clock level
    logic              rst_q;       // agreed restart level
    logic              ce_q;        // agreed chain select level
    logic [FB_W-1:0]   bcnt;        // bit within frame
    logic [FR_W-1:0]   fcnt;        // frame number
    logic [31:0]       fcrc;        // per-frame running crc
    logic [31:0]       scrc;        // whole-stream running crc
    logic [31:0]       rx_crc;      // frame crc shifted in from stream
    logic [31:0]       store;       // stored reference crc
    logic [IC_W-1:0]   icnt;        // init counter
    logic [AD_W-1:0]   uaddr;       // user-mode cell word
    logic [BI_W-1:0]   ubit;        // user-mode bit in word
    logic [31:0]       ucrc;        // user-mode running crc
    logic [5:0]        sbit;        // reference bits folded in at pass end
    logic              fault;       // crc_fault_flag value
    logic              ferr;        // frame crc error seen
    logic              done;        // configuration complete
  } cscm_regs_t;

  cscm_regs_t r_r;   // registered state
  cscm_regs_t r_nxt; // next state

  // config cell words, written while loading, scanned in user mode
  logic [CELL_W_P-1:0] cells_r [CELL_DEPTH_P];

  // ----------------------------------------------------------------
  // crc step instances: frame, stream, user mode
  // ----------------------------------------------------------------
  logic [31:0] fcrc_step;   // frame crc after this bit
  logic [31:0] scrc_step;   // stream crc after this bit
  logic [31:0] ucrc_step;   // user crc after this bit
  logic        ubit_val;    // cell or reference bit fed to the checker
  logic        rx_bit;      // synchronised stream bit
  logic        clk_rise;    // link clock rising edge

  assign rx_bit = r_r.dat_sy[SYNC_N-1];

  cscm_crc32 u_fcrc (.crc_i(r_r.fcrc), .bit_i(rx_bit),   .crc_o(fcrc_step));
  cscm_crc32 u_scrc (.crc_i(r_r.scrc), .bit_i(rx_bit),   .crc_o(scrc_step));
  cscm_crc32 u_ucrc (.crc_i(r_r.ucrc), .bit_i(ubit_val), .crc_o(ucrc_step));

  // only cell contents feed the checker, then the reference bits
  always_comb begin
    if (r_r.st == CSCM_ST_UCHK_END) begin
      ubit_val = r_r.store[5'(31 - r_r.sbit[4:0])];
    end else begin
      ubit_val = cells_r[r_r.uaddr][r_r.ubit];
    end
  end

  // ----------------------------------------------------------------
  // sequencing: one comb filler, one register
  // ----------------------------------------------------------------
  always_comb begin
    r_nxt = r_r;
    // three-flop synchronisers, a change counts when 2nd and 3rd agree
    r_nxt.clk_sy = {r_r.clk_sy[SYNC_N-2:0], serial_config_clock_i};
    r_nxt.dat_sy = {r_r.dat_sy[SYNC_N-2:0], serial_data_in_i};
    r_nxt.rst_sy = {r_r.rst_sy[SYNC_N-2:0], restart_config_n_i};
    r_nxt.ce_sy  = {r_r.ce_sy[SYNC_N-2:0], chain_select_n_i};
    if (r_r.clk_sy[SYNC_N-1] == r_r.clk_sy[SYNC_N-2]) begin
      r_nxt.clk_q = r_r.clk_sy[SYNC_N-1];
    end
    if (r_r.rst_sy[SYNC_N-1] == r_r.rst_sy[SYNC_N-2]) begin
      r_nxt.rst_q = r_r.rst_sy[SYNC_N-1];
    end
    if (r_r.ce_sy[SYNC_N-1] == r_r.ce_sy[SYNC_N-2]) begin
      r_nxt.ce_q = r_r.ce_sy[SYNC_N-1];
    end
    clk_rise = r_nxt.clk_q & ~r_r.clk_q;

    // crc store write works only once configuration is complete, in user and check-end states (inject or restore)
    if (crc_store_wr_i && r_r.done) begin
      r_nxt.store = crc_store_data_i;
    end

    unique case (r_r.st)
      CSCM_ST_RESET: begin
        r_nxt.done  = 1'b0;
        r_nxt.fault = 1'b0;
        r_nxt.ferr  = 1'b0;
        r_nxt.bcnt  = '0;
        r_nxt.fcnt  = '0;
        r_nxt.fcrc  = CRC_INIT;
        r_nxt.scrc  = CRC_INIT;
        // start loading only when chain select is low; it is not looked at during load
        if (r_r.rst_q && !r_r.ce_q) begin
          r_nxt.st = CSCM_ST_LOAD;
        end
      end
      CSCM_ST_LOAD: begin
        if (clk_rise) begin
          r_nxt.bcnt = r_r.bcnt + FB_W'(1);
          if (r_r.bcnt < FB_DATA) begin
            // data bit: into frame crc, stream crc and cell memory
            r_nxt.fcrc = fcrc_step;
            r_nxt.scrc = scrc_step;
          end else begin
            r_nxt.rx_crc = {r_r.rx_crc[30:0], rx_bit};
          end
          if (r_r.bcnt == FB_LAST) begin
            r_nxt.bcnt = '0;
            r_nxt.fcrc = CRC_INIT;
            if ({r_r.rx_crc[30:0], rx_bit} != r_r.fcrc) begin
              r_nxt.ferr = 1'b1;
              r_nxt.st   = CSCM_ST_ERROR;
            end else if (r_r.fcnt == FR_LAST) begin
              r_nxt.store = r_r.scrc;
              r_nxt.icnt  = '0;
              r_nxt.st    = CSCM_ST_INIT;
            end else begin
              r_nxt.fcnt = r_r.fcnt + FR_W'(1);
            end
          end
        end
      end
      CSCM_ST_ERROR: begin
        // parked with config_complete low until restart
      end
      CSCM_ST_INIT: begin
        r_nxt.icnt = r_r.icnt + IC_W'(1);
        if (r_r.icnt == IC_LAST) begin
          r_nxt.done  = 1'b1;
          r_nxt.uaddr = '0;
          r_nxt.ubit  = '0;
          r_nxt.ucrc  = CRC_INIT;
          r_nxt.st    = CSCM_ST_USER;
        end
      end
      CSCM_ST_USER: begin
        // walk every cell bit, config_complete pin is not looked at
        if (HIGH_CORE_P) begin
          r_nxt.ucrc = ucrc_step;
          r_nxt.ubit = r_r.ubit + BI_W'(1);
          if (r_r.ubit == BI_LAST) begin
            r_nxt.ubit  = '0;
            r_nxt.uaddr = r_r.uaddr + AD_W'(1);
            if (r_r.uaddr == AD_LAST) begin
              r_nxt.uaddr = '0;
              r_nxt.sbit  = '0;
              r_nxt.st    = CSCM_ST_UCHK_END;
            end
          end
        end
      end
      CSCM_ST_UCHK_END: begin
        // fold reference in: residue zero when cells match the store
        r_nxt.ucrc = ucrc_step;
        r_nxt.sbit = r_r.sbit + 6'h01;
        if (r_r.sbit == 6'(CRC_W - 1)) begin
          r_nxt.fault = (ucrc_step != CRC_ZERO);
          r_nxt.ucrc  = CRC_INIT;
          r_nxt.st    = CSCM_ST_USER;
        end
      end
      default: r_nxt.st = CSCM_ST_RESET;
    endcase

    // restart low resets the sequence and stops checking
    if (!r_r.rst_q) begin
      r_nxt.st   = CSCM_ST_RESET;
      // pass-out goes high with the state, not a cycle later
      r_nxt.done = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      r_r        <= '0;
      r_r.st     <= CSCM_ST_RESET;
      r_r.clk_sy <= '0;
      r_r.dat_sy <= '0;
      r_r.rst_sy <= '0;                 // restart reads as asserted
      r_r.ce_sy  <= '1;                 // chain select reads idle
      r_r.ce_q   <= 1'b1;
      r_r.fcrc   <= CRC_INIT;
      r_r.scrc   <= CRC_INIT;
      r_r.ucrc   <= CRC_INIT;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ----------------------------------------------------------------
  // cell memory: one word fills per CELL_W_P data bits, wraps on depth
  // ----------------------------------------------------------------
  logic [AD_W-1:0]     waddr_r;   // write word
  logic [BI_W-1:0]     wbit_r;    // write bit
  logic [CELL_W_P-1:0] wword_r;   // word being assembled
  logic                wr_take;   // data bit accepted this cycle

  assign wr_take = (r_r.st == CSCM_ST_LOAD) && clk_rise && (r_r.bcnt < FB_DATA);

  always_ff @(posedge mclk_i) begin
    if (srst_i || r_r.st == CSCM_ST_RESET) begin
      waddr_r <= '0;
      wbit_r  <= '0;
      wword_r <= '0;
    end else if (wr_take) begin
      wword_r[wbit_r] <= rx_bit;
      wbit_r          <= wbit_r + BI_W'(1);
      if (wbit_r == BI_LAST) begin
        cells_r[waddr_r] <= {rx_bit, wword_r[CELL_W_P-2:0]};
        wbit_r           <= '0;
        waddr_r          <= waddr_r + AD_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // pins and status
  // ----------------------------------------------------------------
  logic in_user;   // user or check-end state
  logic scheme_act;// active flash scheme in effect

  assign in_user    = (r_r.st == CSCM_ST_USER) || (r_r.st == CSCM_ST_UCHK_END);
  // boundary-scan load overrides the scheme straps
  assign scheme_act = !boundary_scan_load_i &&
                      ((scheme_select_pins_i == CSCM_SCH_AS) ||
                       (scheme_select_pins_i == CSCM_SCH_AP));

  // open drain: driven low until init starts, then released
  assign config_complete_o      = 1'b0;
  assign config_complete_oe_n_o = !(r_r.st == CSCM_ST_RESET ||
                                    r_r.st == CSCM_ST_LOAD  ||
                                    r_r.st == CSCM_ST_ERROR);

  // chain pass-out driven always, low only once complete
  assign chain_pass_out_n_o      = !r_r.done;
  assign chain_pass_out_n_oe_n_o = 1'b0;

  // serial select and parallel enable are separate lines, each low only during load
  assign serial_flash_select_n_o   = !(scheme_act &&
                                       scheme_select_pins_i == CSCM_SCH_AS &&
                                       r_r.st == CSCM_ST_LOAD);
  assign parallel_flash_enable_n_o = !(scheme_act &&
                                       scheme_select_pins_i == CSCM_SCH_AP &&
                                       r_r.st == CSCM_ST_LOAD);
  // tri-state option floats flash pins in user mode
  assign flash_pins_oe_n_o = (tristate_opt_i && in_user) || !scheme_act;

  // fault flag only when detection is enabled and variant has it
  assign crc_fault_flag_o      = r_r.fault && err_detect_en_i && HIGH_CORE_P;
  assign crc_fault_flag_oe_n_o = !(err_detect_en_i && HIGH_CORE_P);
  assign crc_store_o           = r_r.store;
  assign frame_crc_error_o     = r_r.ferr;
  assign user_mode_o           = in_user;

endmodule : cscm_top

// ---- hdl/cscm_pkg.sv ----
// package: shared constants and types for the configuration status and crc monitor
package cscm_pkg;

  // ----------------------------------------------------------------
  // crc constants
  // ----------------------------------------------------------------
  localparam int          CRC_W       = 32;            // signature width
  localparam logic [31:0] CRC_POLY    = 32'h04c11db7;  // ieee 802 generator, msb-first
  localparam logic [31:0] CRC_INIT    = 32'hffffffff;  // seed for each computation
  localparam logic [31:0] CRC_ZERO    = 32'h00000000;  // clean signature

  // ----------------------------------------------------------------
  // sizes and counts
  // ----------------------------------------------------------------
  localparam int          FRAME_BITS  = 16;            // data bits per frame (default)
  localparam int          NUM_FRAMES  = 4;             // frames per bitstream (default)
  localparam int          CELL_W      = 8;             // config cell word width (default)
  localparam int          INIT_CYC    = 8;             // initialization length in cycles
  localparam int          SYNC_N      = 3;             // pin synchroniser depth

  // ----------------------------------------------------------------
  // configuration scheme selection
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CSCM_SCH_PASSIVE   = 2'h0,   // host clocks data in
    CSCM_SCH_AS        = 2'h1,   // active serial flash
    CSCM_SCH_AP        = 2'h2,   // active parallel flash
    CSCM_SCH_RSVD      = 2'h3    // treated as passive
  } cscm_scheme_t;

endpackage : cscm_pkg

// ---- hdl/cscm_crc32.sv ----
// module: one-bit serial crc32 update step
module cscm_crc32 (
  // crc state
  input  wire logic [31:0] crc_i,
  input  wire logic        bit_i,
  output logic      [31:0] crc_o
);
  import cscm_pkg::*;

  // ----------------------------------------------------------------
  // shift one data bit through the generator polynomial
  // ----------------------------------------------------------------
  always_comb begin
    // feedback is msb xor incoming bit
    if (crc_i[31] ^ bit_i) begin
      crc_o = {crc_i[30:0], 1'b0} ^ CRC_POLY;
    end else begin
      crc_o = {crc_i[30:0], 1'b0};
    end
  end

endmodule : cscm_crc32

// ---- tb/cscm_sva.sv ----
// checker: port-level rules of the configuration status and crc monitor
module cscm_sva (
  // clock and reset
  input wire logic        mclk_i,
  input wire logic        srst_i,
  // pins and options
  input wire logic        restart_config_n_i,
  input wire logic        boundary_scan_load_i,
  input wire logic        tristate_opt_i,
  input wire logic        err_detect_en_i,
  input wire logic        crc_store_wr_i,
  input wire logic [31:0] crc_store_data_i,
  // observed outputs
  input wire logic        chain_pass_out_n_o,
  input wire logic        config_complete_oe_n_o,
  input wire logic        serial_flash_select_n_o,
  input wire logic        parallel_flash_enable_n_o,
  input wire logic        flash_pins_oe_n_o,
  input wire logic [31:0] crc_store_o,
  input wire logic        crc_fault_flag_o,
  input wire logic        frame_crc_error_o,
  input wire logic        user_mode_o
);
  // ------
  // one clock domain, so one default clocking
  // ------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // flag held steady after a pass-end update
  sequence s_flag_hold;
    $stable(crc_fault_flag_o) [*8];
  endsequence
  // restart pin held long enough to pass the synchroniser
  sequence s_restart_held;
    !restart_config_n_i [*8];
  endsequence
  a_chain_user: assert property (chain_pass_out_n_o == !user_mode_o)
    else $error("pass-out and user mode disagree");
  a_release_first: assert property ($rose(user_mode_o) |-> $past(config_complete_oe_n_o))
    else $error("user mode without prior release");
  a_user_released: assert property (user_mode_o |-> config_complete_oe_n_o)
    else $error("status line pulled in user mode");
  a_err_holds: assert property (frame_crc_error_o |-> !config_complete_oe_n_o && !user_mode_o)
    else $error("frame error but status released");
  a_flash_user: assert property (user_mode_o |-> serial_flash_select_n_o && parallel_flash_enable_n_o)
    else $error("flash selected in user mode");
  a_bscan_idle: assert property (boundary_scan_load_i [*6] |-> serial_flash_select_n_o && parallel_flash_enable_n_o)
    else $error("flash selected in boundary-scan load");
  a_tristate_pins: assert property ((user_mode_o && tristate_opt_i) [*3] |-> flash_pins_oe_n_o)
    else $error("flash pins driven with tri-state option");
  a_fault_gate: assert property (!err_detect_en_i [*3] |-> !crc_fault_flag_o)
    else $error("fault flag while detection off");
  a_fault_steady: assert property ($changed(crc_fault_flag_o) && err_detect_en_i |=> s_flag_hold or ##[0:7] !err_detect_en_i)
    else $error("fault flag changed between passes");
  a_store_write: assert property (crc_store_wr_i && user_mode_o |=> crc_store_o == $past(crc_store_data_i))
    else $error("store write not taken");
  a_restart_quits: assert property (s_restart_held |-> !user_mode_o && !config_complete_oe_n_o)
    else $error("restart did not end user mode");
endmodule : cscm_sva

bind cscm_top cscm_sva chk_u (.mclk_i, .srst_i, .restart_config_n_i, .boundary_scan_load_i,
  .tristate_opt_i, .err_detect_en_i, .crc_store_wr_i, .crc_store_data_i, .chain_pass_out_n_o,
  .config_complete_oe_n_o, .serial_flash_select_n_o, .parallel_flash_enable_n_o,
  .flash_pins_oe_n_o, .crc_store_o, .crc_fault_flag_o, .frame_crc_error_o, .user_mode_o);

// ---- tb/cscm_host_model.sv ----
// partner: configuration source sending framed bits on the serial link
module cscm_host_model
  import cscm_pkg::*;
#(
  parameter int FB = 16,  // data bits per frame
  parameter int NF = 4    // frames per stream
) (
  output logic sclk_o,
  output logic sdat_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [63:0] DATA = 64'h3c5a_96e1_0f72_d4b8;  // bitstream content
  logic [31:0] stream_crc;  // whole-stream signature, read by the bench
  initial begin
    sclk_o = 1'b0;
    sdat_o = 1'b0;
  end
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic b);
    crc_step = {c[30:0], 1'b0} ^ ((c[31] ^ b) ? CRC_POLY : 32'h0);
  endfunction : crc_step
  // data changes while the clock is low, held a half period either side
  task automatic put(input logic b);
    sdat_o = b;
    #160;
    sclk_o = 1'b1;
    #160;
    sclk_o = 1'b0;
  endtask : put
  // bad picks the frame whose crc is spoiled, -1 for none
  task automatic send_stream(input int bad);
    logic [31:0] fc;
    stream_crc = CRC_INIT;
    for (int f = 0; f < NF; f++) begin
      fc = CRC_INIT;
      for (int i = 0; i < FB; i++) begin
        put(DATA[f*FB+i]);
        fc = crc_step(fc, DATA[f*FB+i]);
        stream_crc = crc_step(stream_crc, DATA[f*FB+i]);
      end
      if (f == bad) begin
        fc = ~fc;
      end
      for (int i = 31; i >= 0; i--) begin
        put(fc[i]);
      end
    end
    // clock stays low; data line no longer holds the last bit
    sdat_o = ~sdat_o;
  endtask : send_stream
endmodule : cscm_host_model

// ---- tb/tb_cscm_top.sv ----
// testbench: self-checking scenarios for the status and crc monitor
`define CHK(n, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("wrong value %s exp %0h got %0h", n, e, g); \
  end \
end
module tb_cscm_top;
  import cscm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  int n_fail = 0;
  int cmp_count = 0;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic restart_n = 1'b1;
  logic cs_n = 1'b0;
  logic cc_in = 1'b1;  // external party on the status line
  logic bscan = 1'b0;
  logic tri_opt = 1'b0;
  logic det_en = 1'b1;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  cscm_scheme_t sch = CSCM_SCH_AS;
  logic pass_n, cc_oe_n, ssel_n, psel_n, fl_oe_n, fault, fault_oe_n, frame_err, umode, sclk, sdat;
  logic pass_oe_n, cc_o;
  logic [31:0] store;
  // open-drain status wire with pull-up
  wire cc_wire = (cc_oe_n === 1'b0) ? 1'b0 : cc_in;
  always #20 mclk_i = ~mclk_i;
  cscm_host_model host_u (.sclk_o(sclk), .sdat_o(sdat));
  cscm_top #(.CELL_DEPTH_P(8)) dut_u (
    .mclk_i(mclk_i), .srst_i(srst_i), .restart_config_n_i(restart_n),
    .chain_select_n_i(cs_n), .chain_pass_out_n_o(pass_n), .chain_pass_out_n_oe_n_o(pass_oe_n),
    .config_complete_i(cc_wire), .config_complete_o(cc_o), .config_complete_oe_n_o(cc_oe_n),
    .scheme_select_pins_i(sch), .boundary_scan_load_i(bscan), .tristate_opt_i(tri_opt),
    .err_detect_en_i(det_en), .serial_config_clock_i(sclk), .serial_data_in_i(sdat),
    .serial_flash_select_n_o(ssel_n), .parallel_flash_enable_n_o(psel_n),
    .flash_pins_oe_n_o(fl_oe_n), .crc_store_wr_i(wr), .crc_store_data_i(wdata),
    .crc_store_o(store), .crc_fault_flag_o(fault), .crc_fault_flag_oe_n_o(fault_oe_n),
    .frame_crc_error_o(frame_err), .user_mode_o(umode));
  // ------
  // shared helpers
  // ------
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask : cyc
  task automatic restart();
    restart_n = 1'b0;
    cyc(8);
    restart_n = 1'b1;
    cyc(6);
  endtask : restart
  task automatic wait_user();
    for (int i = 0; i < 2000 && umode !== 1'b1; i++) cyc(1);
  endtask : wait_user
  task automatic wr_store(input logic [31:0] v);
    wdata = v;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask : wr_store
  // restart, then stream in while checking the flash selects mid-load
  task automatic load(input cscm_scheme_t s, input int bad, input logic es, input logic ep);
    sch = s;
    restart();
    fork
      host_u.send_stream(bad);
      begin
        cyc(300);
        `CHK("sel_s", es, ssel_n)
        `CHK("sel_p", ep, psel_n)
        `CHK("cc_load", 1'b0, cc_oe_n)
      end
    join
    cyc(4);
  endtask : load
  // ------
  // scenarios
  // ------
  task automatic t_reset_state();
    `CHK("cc_rst", 1'b0, cc_oe_n)
    `CHK("pass_rst", 1'b1, pass_n)
    `CHK("cc_o_low", 1'b0, cc_o)
    `CHK("pass_oe", 1'b0, pass_oe_n)
  endtask : t_reset_state
  task automatic t_load_ok();
    load(CSCM_SCH_AS, -1, 1'b0, 1'b1);
    wait_user();
    `CHK("cc_rel", 1'b1, cc_oe_n)
    `CHK("user", 1'b1, umode)
    `CHK("pass_out", 1'b0, pass_n)
    `CHK("store", host_u.stream_crc, store)
    `CHK("fl_drv", 1'b0, fl_oe_n)
    tri_opt = 1'b1;
    cyc(4);
    `CHK("fl_tri", 1'b1, fl_oe_n)
    tri_opt = 1'b0;
    cyc(200);
    `CHK("fault_ok", 1'b0, fault)
    cc_in = 1'b0;
    cyc(20);
    `CHK("cc_ext", 1'b1, umode)
    cc_in = 1'b1;
  endtask : t_load_ok
  task automatic t_inject();
    logic [31:0] keep;
    keep = store;
    wr_store(~host_u.stream_crc);
    `CHK("store_wr", ~host_u.stream_crc, store)
    cyc(200);
    `CHK("fault_inj", 1'b1, fault)
    `CHK("fault_oe", 1'b0, fault_oe_n)
    det_en = 1'b0;
    cyc(4);
    `CHK("fault_off", 1'b0, fault)
    `CHK("fault_oe_off", 1'b1, fault_oe_n)
    wr_store(keep);
    cyc(200);
    det_en = 1'b1;
    cyc(4);
    `CHK("fault_back", 1'b0, fault)
  endtask : t_inject
  task automatic t_restart();
    restart_n = 1'b0;
    cyc(8);
    `CHK("umode_rs", 1'b0, umode)
    cs_n = 1'b1;
    sch = CSCM_SCH_PASSIVE;
    restart_n = 1'b1;
    cyc(6);
    host_u.send_stream(-1);
    cyc(40);
    `CHK("no_sel", 1'b0, umode)
    `CHK("no_sel_cc", 1'b0, cc_oe_n)
    `CHK("fl_pas", 1'b1, fl_oe_n)
    `CHK("sel_pas", 1'b1, ssel_n)
    cs_n = 1'b0;
  endtask : t_restart
  task automatic t_bad_frame();
    load(CSCM_SCH_AP, 2, 1'b1, 1'b0);
    cyc(20);
    `CHK("frm_err", 1'b1, frame_err)
    `CHK("frm_cc", 1'b0, cc_oe_n)
  endtask : t_bad_frame
  task automatic t_bscan();
    bscan = 1'b1;
    load(CSCM_SCH_AS, -1, 1'b1, 1'b1);
    wait_user();
    `CHK("bs_user", 1'b1, umode)
  endtask : t_bscan
  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report
  // watchdog: about seven times the expected run
  initial begin
    #2000000;
    n_fail++;
    final_report();
  end
  initial begin
    cyc(8);
    srst_i = 1'b0;
    cyc(2);
    t_reset_state();
    t_load_ok();
    t_inject();
    t_restart();
    t_bad_frame();
    t_bscan();
    final_report();
  end
endmodule : tb_cscm_top
